// *** hdl/jtap_pkg.sv ***
// constants, types and state codes for the test access port
// assumes one system clock that oversamples the test clock pin by at least 4x
package jtap_pkg;

  // ==========================================================
  // widths and lengths
  localparam int unsigned IR_LEN      = 4;
  localparam int unsigned ID_LEN      = 32;
  localparam int unsigned SYNC_STAGES = 2;

  // ==========================================================
  // instruction codes and capture / reset values
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;
  localparam logic [3:0]  IR_IDCODE   = 4'h1;
  localparam logic [3:0]  IR_BYPASS   = 4'hF;
  localparam logic [3:0]  IR_RESET    = 4'h1;
  // identity value is arbitrary, lsb set as the scan standard needs
  localparam logic [31:0] IDCODE_VAL  = 32'h0000_0001;
  localparam logic [2:0]  ONES_RESET  = 3'h5;

  // ==========================================================
  // tap controller states
  typedef enum logic [3:0] {
    ST_TLR        = 4'hF,
    ST_IDLE       = 4'hC,
    ST_SEL_DR     = 4'h7,
    ST_CAP_DR     = 4'h6,
    ST_SHIFT_DR   = 4'h2,
    ST_EXIT1_DR   = 4'h1,
    ST_PAUSE_DR   = 4'h3,
    ST_EXIT2_DR   = 4'h0,
    ST_UPD_DR     = 4'h5,
    ST_SEL_IR     = 4'h4,
    ST_CAP_IR     = 4'hE,
    ST_SHIFT_IR   = 4'hA,
    ST_EXIT1_IR   = 4'h9,
    ST_PAUSE_IR   = 4'hB,
    ST_EXIT2_IR   = 4'h8,
    ST_UPD_IR     = 4'hD
  } jtap_state_t;

  // pin group, resolved for pulls, before synchronising
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } jtap_pins_t;

endpackage : jtap_pkg

// *** hdl/jtap_sync.sv ***
// two-stage synchroniser for a group of pin levels
// assumes inputs are asynchronous to clock_i; only the second stage is read
`timescale 1ns/1ns
module jtap_sync
  import jtap_pkg::*;
(
  input  wire logic       clock_i,
  input  wire logic       sys_rst_i,
  input  wire jtap_pins_t d_i,
  output jtap_pins_t      q_o
);

  // ==========================================================
  // stages
  jtap_pins_t meta_r;
  jtap_pins_t sync_r;

  // reset value keeps trst_n low so the tap stays reset until pins settle
  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      meta_r <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
      sync_r <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
    end
  end

  assign q_o = sync_r;

endmodule : jtap_sync

// *** hdl/jtap_port.sv ***
// boundary-scan test access port: tap controller, instruction, bypass and id registers
// assumes clock_i oversamples tck_i; each *_drive_i tells whether the far end drives that pin
`timescale 1ns/1ns
module jtap_port
  import jtap_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        sys_rst_i,
  input  wire logic        tck_i,
  input  wire logic        tms_i,
  input  wire logic        tms_drive_i,
  input  wire logic        tdi_i,
  input  wire logic        tdi_drive_i,
  input  wire logic        trst_n_i,
  input  wire logic        trst_drive_i,
  output logic             tdo_o,
  output logic             tdo_oe_o,
  output jtap_state_t      tap_state_o,
  output logic             test_logic_reset_o,
  output logic [IR_LEN-1:0] ir_value_o
);

  // ==========================================================
  // next-state function of the tap controller
  function automatic jtap_state_t tap_next(input jtap_state_t s, input logic tms);
    jtap_state_t n;
    n = ST_TLR;
    case (s)
      ST_TLR:      n = tms ? ST_TLR      : ST_IDLE;
      ST_IDLE:     n = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   n = tms ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: n = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: n = tms ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: n = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: n = tms ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   n = tms ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   n = tms ? ST_TLR      : ST_CAP_IR;
      ST_CAP_IR:   n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: n = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: n = tms ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: n = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: n = tms ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   n = tms ? ST_SEL_DR   : ST_IDLE;
      default:     n = ST_TLR;
    endcase
    return n;
  endfunction : tap_next

  // ==========================================================
  // pin resolution and synchronisation
  jtap_pins_t  pins_raw;
  jtap_pins_t  pins_s;

  assign pins_raw.tck    = tck_i;
  assign pins_raw.tms    = tms_drive_i  ? tms_i    : 1'b1;
  assign pins_raw.tdi    = tdi_drive_i  ? tdi_i    : 1'b1;
  assign pins_raw.trst_n = trst_drive_i ? trst_n_i : 1'b0;

  jtap_sync u_sync (
    .clock_i   (clock_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (pins_raw),
    .q_o       (pins_s)
  );

  // ==========================================================
  // test clock edge detection
  logic        tck_prev_r;
  wire  logic  tck_rise;
  wire  logic  tck_fall;
  wire  logic  trst_active;

  assign tck_rise    = pins_s.tck & ~tck_prev_r;
  assign tck_fall    = ~pins_s.tck & tck_prev_r;
  assign trst_active = ~pins_s.trst_n;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      tck_prev_r <= 1'b0;
    end else begin
      tck_prev_r <= pins_s.tck;
    end
  end

  // ==========================================================
  // tap state machine
  jtap_state_t state_r;
  jtap_state_t state_nxt;
  logic        tlr_r;

  // reset wins over any edge; no tck edge is needed to leave a scan
  assign state_nxt = trst_active ? ST_TLR :
                     tck_rise    ? tap_next(state_r, pins_s.tms) :
                                   state_r;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state_r <= ST_TLR;
      tlr_r   <= 1'b1;
    end else begin
      state_r <= state_nxt;
      tlr_r   <= (state_nxt == ST_TLR);
    end
  end

  // ==========================================================
  // instruction and data registers
  logic [IR_LEN-1:0] ir_sh_r;
  logic [IR_LEN-1:0] ir_r;
  logic [ID_LEN-1:0] id_sh_r;
  logic              bypass_r;
  wire  logic        sel_id;
  wire  logic        shifting;
  wire  logic        scan_bit;

  assign sel_id   = (ir_r == IR_IDCODE);
  assign shifting = (state_r == ST_SHIFT_DR) || (state_r == ST_SHIFT_IR);
  // unknown codes fall back to bypass so the chain length stays defined
  assign scan_bit = (state_r == ST_SHIFT_IR) ? ir_sh_r[0] :
                    sel_id                   ? id_sh_r[0] : bypass_r;

  // entering test-logic-reset reloads the instruction at once, not at the next rise
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || trst_active || (state_nxt == ST_TLR)) begin
      ir_sh_r  <= IR_CAPTURE;
      ir_r     <= IR_RESET;
      id_sh_r  <= IDCODE_VAL;
      bypass_r <= 1'b0;
    end else if (tck_rise) begin
      case (state_r)
        ST_TLR:      ir_r     <= IR_RESET;
        ST_CAP_IR:   ir_sh_r  <= IR_CAPTURE;
        ST_SHIFT_IR: ir_sh_r  <= {pins_s.tdi, ir_sh_r[IR_LEN-1:1]};
        ST_UPD_IR:   ir_r     <= ir_sh_r;
        ST_CAP_DR: begin
          id_sh_r  <= IDCODE_VAL;
          bypass_r <= 1'b0;
        end
        ST_SHIFT_DR: begin
          if (sel_id) begin
            id_sh_r <= {pins_s.tdi, id_sh_r[ID_LEN-1:1]};
          end else begin
            bypass_r <= pins_s.tdi;
          end
        end
        default: begin
          ir_r <= ir_r;
        end
      endcase
    end
  end

  // ==========================================================
  // serial output, launched on the falling test clock edge
  logic tdo_r;
  logic tdo_oe_r;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i || trst_active) begin
      tdo_r    <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r    <= shifting ? scan_bit : 1'b0;
      tdo_oe_r <= shifting;
    end
  end

  assign tdo_o              = tdo_r;
  assign tdo_oe_o           = tdo_oe_r;
  assign tap_state_o        = state_r;
  assign test_logic_reset_o = tlr_r;
  assign ir_value_o         = ir_r;

  // ==========================================================
  // checks
  logic [2:0] ones_cnt_r;

  // counts consecutive rising edges with mode-select high
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || trst_active) begin
      ones_cnt_r <= ONES_RESET;
    end else if (tck_rise) begin
      if (!pins_s.tms) begin
        ones_cnt_r <= 3'h0;
      end else if (ones_cnt_r != ONES_RESET) begin
        ones_cnt_r <= ones_cnt_r + 3'h1;
      end
    end
  end

  a_tms_pull_high: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (!tms_drive_i)[*3] |-> pins_s.tms)
    else $error("undriven mode-select did not read high");

  a_tdi_pull_high: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (!tdi_drive_i)[*3] |-> pins_s.tdi)
    else $error("undriven data-in did not read high");

  a_tdo_fall_only: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $changed(tdo_r) |-> $past(tck_fall) || $past(trst_active))
    else $error("data-out moved without a falling test clock");

  // enable follows the shift state seen at each falling edge; it may outlast the exit rise
  a_tdo_oe_shift: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    tck_fall && !trst_active |=> (tdo_oe_r == $past(shifting)))
    else $error("data-out enable does not follow the shift state");

  a_tdo_oe_fall: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $changed(tdo_oe_r) |-> $past(tck_fall) || $past(trst_active))
    else $error("data-out enable moved without a falling test clock");

  a_state_tck_only: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $changed(state_r) |-> $past(tck_rise) || $past(trst_active))
    else $error("tap state moved without a test clock edge");

  a_trst_forces_tlr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    trst_active |=> (state_r == ST_TLR) && !tdo_oe_r && test_logic_reset_o)
    else $error("test reset did not force test-logic-reset");

  a_trst_pull_low: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (!trst_drive_i)[*3] |=> (state_r == ST_TLR))
    else $error("undriven test reset did not hold the tap reset");

  a_five_ones_tlr: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (ones_cnt_r == ONES_RESET) |-> (state_r == ST_TLR))
    else $error("five high mode-select edges did not reach reset");

  a_tlr_ir_reset: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (state_r == ST_TLR) |-> (ir_r == IR_RESET))
    else $error("instruction not reset in test-logic-reset");

  a_shift_dr_hold: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    tck_rise && !trst_active && (state_r == ST_CAP_DR) && !pins_s.tms
    |=> (state_r == ST_SHIFT_DR) ##1 (state_r == ST_SHIFT_DR))
    else $error("capture-dr with mode-select low did not enter shift-dr");

endmodule : jtap_port

// *** tb/jtap_ctl_model.sv ***
// model of the outside test controller: drives clock, mode, data-in and reset pins
// assumes clock_i is the bench clock; one test clock period is 8 of its cycles
`timescale 1ns/1ns
module jtap_ctl_model (
  input  wire logic clock_i,
  input  wire logic tdo_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tms_drive_o,
  output logic      tdi_o,
  output logic      tdi_drive_o,
  output logic      trst_n_o,
  output logic      trst_drive_o
);
  // ==========================================================
  // power-up levels, test reset held low
  initial begin
    tck_o        = 1'h0;
    tms_o        = 1'h1;
    tms_drive_o  = 1'h1;
    tdi_o        = 1'h1;
    tdi_drive_o  = 1'h1;
    trst_n_o     = 1'h0;
    trst_drive_o = 1'h1;
  end
  // ==========================================================
  // one clock period; a released line shows its inverse, not a stale level
  task automatic step(input logic ms, input logic d, output logic a, output logic b);
    @(posedge clock_i);
    tms_o <= tms_drive_o ? ms : ~tms_o;
    tdi_o <= tdi_drive_o ? d : ~tdi_o;
    repeat (3) @(posedge clock_i);
    tck_o <= 1'h1;
    @(negedge clock_i);
    a = tdo_i;
    repeat (4) @(posedge clock_i);
    tck_o <= 1'h0;
    @(negedge clock_i);
    b = tdo_i;
  endtask : step
  task automatic set_drv(input logic ms_drv, input logic d_drv);
    @(posedge clock_i);
    tms_drive_o <= ms_drv;
    tdi_drive_o <= d_drv;
  endtask : set_drv
  task automatic set_trst(input logic lvl, input logic drv);
    @(posedge clock_i);
    trst_n_o     <= drv ? lvl : ~trst_n_o;
    trst_drive_o <= drv;
  endtask : set_trst
  // mode line toggles while the clock stands still
  task automatic wiggle(input int n);
    repeat (n) begin
      @(posedge clock_i);
      tms_o <= ~tms_o;
    end
  endtask : wiggle
endmodule : jtap_ctl_model

// *** tb/jtap_port_tb.sv ***
// self-checking bench for the test access port
// assumes the controller model drives every link pin except data-out, which the bench resolves; the bench calls its tasks
`timescale 1ns/1ns
module jtap_port_tb;
  import jtap_pkg::*;
  logic        clock_i;
  logic        sys_rst_i;
  wire logic   tck, tms, tms_drv, tdi, tdi_drv, trst_n, trst_drv, tdo_w;
  logic        tdo, tdo_oe, tlr;
  jtap_state_t st;
  logic [3:0]  ir;
  int          miscompares = 0;
  int          tests_run = 0;
  // data-out floats while its enable is low
  assign tdo_w = tdo_oe ? tdo : 1'hZ;
  initial begin
    clock_i = 1'h0;
    forever #4 clock_i = ~clock_i;
  end
  jtap_port dut_u (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .tck_i(tck), .tms_i(tms), .tms_drive_i(tms_drv),
    .tdi_i(tdi), .tdi_drive_i(tdi_drv), .trst_n_i(trst_n), .trst_drive_i(trst_drv), .tdo_o(tdo),
    .tdo_oe_o(tdo_oe), .tap_state_o(st), .test_logic_reset_o(tlr), .ir_value_o(ir));
  jtap_ctl_model ctl_u (.clock_i(clock_i), .tdo_i(tdo_w), .tck_o(tck), .tms_o(tms), .tms_drive_o(tms_drv),
    .tdi_o(tdi), .tdi_drive_o(tdi_drv), .trst_n_o(trst_n), .trst_drive_o(trst_drv));
  // ==========================================================
  // checking and verdict
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    if (miscompares == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize
  // one period; ea is data-out seen before the rise, held through it
  task automatic go(input logic ms, input logic d, input jtap_state_t es, input logic ea);
    logic a, b;
    ctl_u.step(ms, d, a, b);
    chk(st, es);
    chk({3'h0, a}, {3'h0, ea});
    chk({3'h0, b}, {3'h0, a});
  endtask : go
  task automatic to_shdr();
    go(1'h1, 1'h1, ST_SEL_DR, 1'hZ);
    go(1'h0, 1'h1, ST_CAP_DR, 1'hZ);
    go(1'h0, 1'h1, ST_SHIFT_DR, 1'hZ);
  endtask : to_shdr
  // ==========================================================
  // scenarios
  task automatic t_reset();
    go(1'h0, 1'h1, ST_TLR, 1'hZ);
    ctl_u.set_trst(1'h1, 1'h0);
    go(1'h0, 1'h1, ST_TLR, 1'hZ);
    chk({3'h0, tlr}, 4'h1);
    ctl_u.set_trst(1'h1, 1'h1);
    repeat (8) @(posedge clock_i);
  endtask : t_reset
  task automatic t_id();
    go(1'h0, 1'h1, ST_IDLE, 1'hZ);
    chk({3'h0, tlr}, 4'h0);
    to_shdr();
    for (int i = 0; i < int'(ID_LEN); i++) begin
      go(i == 31, 1'h1, (i == 31) ? ST_EXIT1_DR : ST_SHIFT_DR, IDCODE_VAL[i]);
    end
    go(1'h1, 1'h1, ST_UPD_DR, 1'hZ);
    go(1'h0, 1'h1, ST_IDLE, 1'hZ);
  endtask : t_id
  // undriven data-in loads all ones into the instruction
  task automatic t_ir();
    ctl_u.set_drv(1'h1, 1'h0);
    go(1'h1, 1'h0, ST_SEL_DR, 1'hZ);
    go(1'h1, 1'h0, ST_SEL_IR, 1'hZ);
    go(1'h0, 1'h0, ST_CAP_IR, 1'hZ);
    go(1'h0, 1'h0, ST_SHIFT_IR, 1'hZ);
    for (int i = 0; i < int'(IR_LEN); i++) begin
      go(i == 3, 1'h0, (i == 3) ? ST_EXIT1_IR : ST_SHIFT_IR, IR_CAPTURE[i]);
    end
    go(1'h1, 1'h0, ST_UPD_IR, 1'hZ);
    go(1'h0, 1'h0, ST_IDLE, 1'hZ);
    chk(ir, IR_BYPASS);
    ctl_u.set_drv(1'h1, 1'h1);
  endtask : t_ir
  // bypass bit through pause and exit2 back into shift
  task automatic t_byp();
    to_shdr();
    go(1'h0, 1'h1, ST_SHIFT_DR, 1'h0);
    go(1'h1, 1'h1, ST_EXIT1_DR, 1'h1);
    go(1'h0, 1'h0, ST_PAUSE_DR, 1'hZ);
    go(1'h1, 1'h0, ST_EXIT2_DR, 1'hZ);
    go(1'h0, 1'h0, ST_SHIFT_DR, 1'hZ);
    go(1'h1, 1'h0, ST_EXIT1_DR, 1'h1);
    go(1'h1, 1'h1, ST_UPD_DR, 1'hZ);
    go(1'h0, 1'h1, ST_IDLE, 1'hZ);
  endtask : t_byp
  // undriven mode line reads high and walks to reset
  task automatic t_pull();
    ctl_u.set_drv(1'h0, 1'h1);
    go(1'h0, 1'h1, ST_SEL_DR, 1'hZ);
    go(1'h0, 1'h1, ST_SEL_IR, 1'hZ);
    go(1'h0, 1'h1, ST_TLR, 1'hZ);
    chk(ir, IR_RESET);
    go(1'h0, 1'h1, ST_TLR, 1'hZ);
    go(1'h0, 1'h1, ST_TLR, 1'hZ);
    chk(ir, IR_RESET);
    ctl_u.set_drv(1'h1, 1'h1);
  endtask : t_pull
  task automatic t_trst();
    go(1'h0, 1'h1, ST_IDLE, 1'hZ);
    to_shdr();
    go(1'h0, 1'h1, ST_SHIFT_DR, IDCODE_VAL[0]);
    ctl_u.wiggle(20);
    @(negedge clock_i);
    chk(st, ST_SHIFT_DR);
    chk({3'h0, tdo_w}, {3'h0, IDCODE_VAL[1]});
    ctl_u.set_trst(1'h0, 1'h1);
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    chk(st, ST_TLR);
    chk({3'h0, tdo_w}, {3'h0, 1'hZ});
    ctl_u.set_trst(1'h1, 1'h1);
  endtask : t_trst
  // ==========================================================
  // hang guard and main sequence
  initial begin
    repeat (100000) @(posedge clock_i);
    miscompares++;
    summarize();
  end
  initial begin
    sys_rst_i = 1'h1;
    repeat (10) @(posedge clock_i);
    sys_rst_i <= 1'h0;
    t_reset();
    t_id();
    t_ir();
    t_byp();
    t_pull();
    t_trst();
    summarize();
  end
endmodule : jtap_port_tb
